// ===== verilog/mcss_cfg.svh
// Address map, field positions, reset values and counts for the clock source switch
`ifndef MCSS_CFG_SVH
`define MCSS_CFG_SVH

`define MCSS_OFF_MODE      8'h00
`define MCSS_OFF_RUN       8'h04
`define MCSS_OFF_STAT      8'h08
`define MCSS_OFF_STSEL     8'h0C
`define MCSS_OFF_SEL       8'h10
`define MCSS_OFF_FREQ      8'h14

`define MCSS_RST_MODE      8'h00
`define MCSS_RST_RUN       8'h80
`define MCSS_RST_STSEL     8'h07
`define MCSS_RST_SEL       8'h00

`define MCSS_BIT_SYS_STOP  7
`define MCSS_BIT_FAST_STOP 0
`define MCSS_BIT_SEL       4
`define MCSS_BIT_STATUS    5

`define MCSS_FREQ_OLD_TICKS 2'h3
`define MCSS_FREQ_NEW_TICKS 2'h3
`define MCSS_CNT_W          19

`endif

// ===== verilog/mcss_pkg.sv
// Types shared by the clock source switch
package mcss_pkg;

    typedef struct packed {
        logic       external_clock_input_select;
        logic       system_osc_select;
        logic [4:0] unused;
        logic       oscillator_gain_high;
    } mcss_mode_s;

    typedef enum logic [4:0] {
        ST_RUN    = 5'h01,
        ST_DRAIN  = 5'h02,
        ST_ALIGN  = 5'h04,
        ST_STOP   = 5'h08,
        ST_STAB   = 5'h10
    } mcss_state_e;

endpackage

// ===== verilog/mcss_main_clock_switch.sv
// Main system clock source switch with its register file on AHB-Lite
`timescale 1ns/1ps
`default_nettype none
`include "mcss_cfg.svh"

// How it works
// - Freq change: three old ticks, three new-tick wait
// - Every reset starts on the internal oscillator
// - Mode register accepts one write per reset
// - Select field sets post-STOP crystal wait
// - Stop bit clear runs crystal in crystal mode only, set stops it
// - Status counter bits fill from MSB downward
// - Select bit 4 chooses the main source
// - Status bit 5 shows the active source
// - Old clock runs bounded cycles after select write
// - CPU and peripherals share one source always
// - HALT enters from either source, no setup
// - Both bits zero makes crystal pins inputs
module mcss_main_clock_switch (
    input  wire logic        hclk,
    input  wire logic        hresetn,
    input  wire logic        hsel,
    input  wire logic [31:0] haddr,
    input  wire logic [1:0]  htrans,
    input  wire logic        hwrite,
    input  wire logic [2:0]  hsize,
    input  wire logic [31:0] hwdata,
    input  wire logic        hready,
    output logic             hreadyout,
    output logic [31:0]      hrdata,
    output logic             hresp,
    input  wire logic [2:0]  opt_freq_sel,
    input  wire logic        fast_osc_in,
    input  wire logic        crystal_osc_in,
    input  wire logic        ext_clk_in,
    input  wire logic        halt_req,
    input  wire logic        stop_req,
    input  wire logic        wake_req,
    output logic             fast_osc_enable,
    output logic [2:0]       fast_osc_freq,
    output logic             crystal_osc_enable,
    output logic             crystal_gain_high,
    output logic             crystal_port_data,
    output logic             cpu_clk_en,
    output logic             periph_clk_en
);

    // Threshold of the stabilization counter for a select code
    function automatic logic [`MCSS_CNT_W-1:0] stab_limit(input logic [2:0] code);
        logic [`MCSS_CNT_W-1:0] lim;
        lim = '0;
        case (code)
            3'h0: lim[8]  = 1'b1;
            3'h1: lim[9]  = 1'b1;
            3'h2: lim[10] = 1'b1;
            3'h3: lim[11] = 1'b1;
            3'h4: lim[13] = 1'b1;
            3'h5: lim[15] = 1'b1;
            3'h6: lim[17] = 1'b1;
            default: lim[18] = 1'b1;
        endcase
        return lim;
    endfunction

    // Rising edge of a synchronised level
    function automatic logic rise(input logic now, input logic was);
        return now & ~was;
    endfunction

    // Registers
    mcss_pkg::mcss_mode_s   mode_r;
    logic                   mode_locked_r;
    logic [7:0]             stsel_r;
    logic                   sys_stop_r;
    logic                   fast_stop_r;
    logic                   sel_r;
    logic                   status_r;
    logic [2:0]             freq_r;
    logic [2:0]             freq_pend_r;
    logic                   strap_done_r;

    // Bus pipeline
    logic                   wr_pend_r;
    logic                   rd_pend_r;
    logic [7:0]             addr_r;
    logic [7:0]             rd_data;

    // Pin synchronisers and edge history
    logic [1:0]             fast_sync_r;
    logic [1:0]             xtal_sync_r;
    logic [1:0]             ext_sync_r;
    logic                   fast_prev_r;
    logic                   sys_prev_r;

    // Switch control
    mcss_pkg::mcss_state_e  state_r;
    logic [`MCSS_CNT_W-1:0] stab_cnt_r;
    logic [1:0]             fq_phase_r;
    logic [1:0]             fq_cnt_r;
    logic                   halt_r;

    logic                   fast_tick;
    logic                   sys_level;
    logic                   sys_tick;
    logic                   old_tick;
    logic                   new_tick;
    logic                   main_tick;
    logic                   crystal_mode;
    logic                   sys_run;
    logic                   addr_ok;
    logic                   wr_now;
    logic [7:0]             wbyte;

    assign addr_ok = hsel & hready & htrans[1];
    assign wr_now  = wr_pend_r;
    assign wbyte   = hwdata[7:0];

    // Address phase capture; reads take one wait state so prior writes have landed
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            wr_pend_r <= 1'b0;
            rd_pend_r <= 1'b0;
            addr_r    <= 8'h00;
        end else begin
            wr_pend_r <= addr_ok & hwrite;
            rd_pend_r <= addr_ok & ~hwrite;
            if (addr_ok) begin
                addr_r <= haddr[7:0];
            end
        end
    end

    assign hreadyout = ~rd_pend_r;
    assign hresp     = 1'b0;

    // Read decode, unmapped reads give zero
    always_comb begin
        rd_data = 8'h00;
        if (addr_r == `MCSS_OFF_MODE) begin
            rd_data = mode_r;
        end else if (addr_r == `MCSS_OFF_RUN) begin
            rd_data[`MCSS_BIT_SYS_STOP]  = sys_stop_r;
            rd_data[`MCSS_BIT_FAST_STOP] = fast_stop_r;
        end else if (addr_r == `MCSS_OFF_STAT) begin
            // Bit 7 fills first, bit 0 last
            rd_data = {stab_cnt_r >= stab_limit(3'h0), stab_cnt_r >= stab_limit(3'h1),
                       stab_cnt_r >= stab_limit(3'h2), stab_cnt_r >= stab_limit(3'h3),
                       stab_cnt_r >= stab_limit(3'h4), stab_cnt_r >= stab_limit(3'h5),
                       stab_cnt_r >= stab_limit(3'h6), stab_cnt_r >= stab_limit(3'h7)};
        end else if (addr_r == `MCSS_OFF_STSEL) begin
            rd_data = stsel_r;
        end else if (addr_r == `MCSS_OFF_SEL) begin
            rd_data[`MCSS_BIT_SEL]    = sel_r;
            rd_data[`MCSS_BIT_STATUS] = status_r;
        end else if (addr_r == `MCSS_OFF_FREQ) begin
            rd_data[2:0] = freq_pend_r;
        end
    end

    // Read data is registered in the wait-state cycle
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            hrdata <= 32'h00000000;
        end else if (rd_pend_r) begin
            hrdata <= {24'h000000, rd_data};
        end
    end

    // Mode register: the first write after reset sticks, later ones are dropped
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            mode_r        <= `MCSS_RST_MODE;
            mode_locked_r <= 1'b0;
        end else if (wr_now && addr_r == `MCSS_OFF_MODE && !mode_locked_r) begin
            mode_r        <= wbyte;
            mode_locked_r <= 1'b1;
        end
    end

    // Oscillator run control and stabilization select
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            sys_stop_r  <= 1'(`MCSS_RST_RUN >> `MCSS_BIT_SYS_STOP);
            fast_stop_r <= 1'b0;
            stsel_r     <= `MCSS_RST_STSEL;
        end else if (wr_now && addr_r == `MCSS_OFF_RUN) begin
            sys_stop_r  <= wbyte[`MCSS_BIT_SYS_STOP];
            fast_stop_r <= wbyte[`MCSS_BIT_FAST_STOP];
        end else if (wr_now && addr_r == `MCSS_OFF_STSEL) begin
            stsel_r     <= {5'h00, wbyte[2:0]};
        end
    end

    // Source select; reset always returns to the internal oscillator
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            sel_r <= 1'b0;
        end else if (wr_now && addr_r == `MCSS_OFF_SEL) begin
            sel_r <= wbyte[`MCSS_BIT_SEL];
        end
    end

    // Divider strap is caught after reset release, not inside the reset branch
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            strap_done_r <= 1'b0;
            freq_pend_r  <= 3'h0;
        end else if (!strap_done_r) begin
            strap_done_r <= 1'b1;
            freq_pend_r  <= opt_freq_sel;
        end else if (wr_now && addr_r == `MCSS_OFF_FREQ) begin
            freq_pend_r  <= wbyte[2:0];
        end
    end

    // Two-flop synchronisers for the oscillator pins
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            fast_sync_r <= 2'h0;
            xtal_sync_r <= 2'h0;
            ext_sync_r  <= 2'h0;
        end else begin
            fast_sync_r <= {fast_sync_r[0], fast_osc_in};
            xtal_sync_r <= {xtal_sync_r[0], crystal_osc_in};
            ext_sync_r  <= {ext_sync_r[0], ext_clk_in};
        end
    end

    // Oscillator configuration seen by the pads
    assign crystal_mode       = mode_r.system_osc_select & ~mode_r.external_clock_input_select;
    assign sys_run            = mode_r.system_osc_select & ~sys_stop_r &
                                (state_r != mcss_pkg::ST_STOP);
    assign crystal_osc_enable = crystal_mode & sys_run;
    assign crystal_gain_high  = mode_r.oscillator_gain_high;
    assign fast_osc_enable    = ~fast_stop_r & (state_r != mcss_pkg::ST_STOP);
    // Both select bits low leave the crystal pin as a plain input
    assign crystal_port_data  = ~mode_r.system_osc_select &
                                ~mode_r.external_clock_input_select & xtal_sync_r[1];

    // External input is blocked by the stop bit, as is the crystal
    assign sys_level = mode_r.external_clock_input_select ? ext_sync_r[1] : xtal_sync_r[1];
    assign sys_tick  = sys_run & rise(sys_level, sys_prev_r);
    assign fast_tick = fast_osc_enable & rise(fast_sync_r[1], fast_prev_r);

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            fast_prev_r <= 1'b0;
            sys_prev_r  <= 1'b0;
        end else begin
            fast_prev_r <= fast_sync_r[1];
            sys_prev_r  <= sys_level;
        end
    end

    // Stabilization counter runs on crystal edges and clears while it is stopped
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            stab_cnt_r <= '0;
        end else if (!crystal_osc_enable) begin
            stab_cnt_r <= '0;
        end else if (sys_tick && !stab_cnt_r[`MCSS_CNT_W-1]) begin
            stab_cnt_r <= stab_cnt_r + 1'b1;
        end
    end

    assign old_tick = status_r ? sys_tick : fast_tick;
    assign new_tick = status_r ? fast_tick : sys_tick;

    // Switch sequencer; the old clock keeps running until one of its ticks is
    // out and the new source then ticks, so both ratios of the bound hold
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            state_r  <= mcss_pkg::ST_RUN;
            status_r <= 1'b0;
        end else begin
            case (state_r)
                mcss_pkg::ST_RUN: begin
                    if (stop_req) begin
                        state_r <= mcss_pkg::ST_STOP;
                    end else if (sel_r != status_r) begin
                        state_r <= mcss_pkg::ST_DRAIN;
                    end
                end
                mcss_pkg::ST_DRAIN: begin
                    if (old_tick) begin
                        state_r <= mcss_pkg::ST_ALIGN;
                    end
                end
                mcss_pkg::ST_ALIGN: begin
                    // Status flips on the first new-source edge in ALIGN; the new source drives from its next edge
                    if (new_tick) begin
                        status_r <= ~status_r;
                        state_r  <= mcss_pkg::ST_RUN;
                    end
                end
                mcss_pkg::ST_STOP: begin
                    if (wake_req) begin
                        state_r <= (status_r && crystal_mode) ? mcss_pkg::ST_STAB
                                                              : mcss_pkg::ST_RUN;
                    end
                end
                mcss_pkg::ST_STAB: begin
                    if (stab_cnt_r >= stab_limit(stsel_r[2:0])) begin
                        state_r <= mcss_pkg::ST_RUN;
                    end
                end
                default: begin
                    state_r <= mcss_pkg::ST_RUN;
                end
            endcase
        end
    end

    // Divider change: three old-rate ticks, then apply, then a three-tick hold
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            fq_phase_r <= 2'h0;
            fq_cnt_r   <= 2'h0;
            freq_r     <= 3'h0;
        end else begin
            case (fq_phase_r)
                2'h0: begin
                    if (!strap_done_r) begin
                        freq_r <= opt_freq_sel;
                    end else if (freq_pend_r != freq_r) begin
                        fq_phase_r <= 2'h1;
                        fq_cnt_r   <= 2'h0;
                    end
                end
                2'h1: begin
                    if (fast_tick) begin
                        fq_cnt_r <= fq_cnt_r + 2'h1;
                        if (fq_cnt_r == `MCSS_FREQ_OLD_TICKS - 2'h1) begin
                            freq_r     <= freq_pend_r;
                            fq_phase_r <= 2'h2;
                            fq_cnt_r   <= 2'h0;
                        end
                    end
                end
                default: begin
                    if (fast_tick) begin
                        fq_cnt_r <= fq_cnt_r + 2'h1;
                        if (fq_cnt_r == `MCSS_FREQ_NEW_TICKS - 2'h1) begin
                            fq_phase_r <= 2'h0;
                        end
                    end
                end
            endcase
        end
    end

    assign fast_osc_freq = freq_r;

    // HALT needs no setup; wake wins over a same-cycle request
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            halt_r <= 1'b0;
        end else if (wake_req) begin
            halt_r <= 1'b0;
        end else if (halt_req) begin
            halt_r <= 1'b1;
        end
    end

    // One enable feeds both CPU and peripherals, so they never split sources
    assign main_tick = old_tick & (state_r != mcss_pkg::ST_STOP) &
                       (state_r != mcss_pkg::ST_STAB) &
                       !(fq_phase_r == 2'h2 && !status_r);
    assign periph_clk_en = main_tick;
    assign cpu_clk_en    = main_tick & ~halt_r;

    // Width and the low transfer-type bit are unused: only word accesses are supported
    logic unused_ok;
    assign unused_ok = &{1'b0, hsize, haddr[31:8], hwdata[31:8], htrans[0], stsel_r[7:3]};

endmodule
`default_nettype wire

// ===== testbench/mcss_checker.sv
// Bus timing, shared clock and reset checks for the clock source switch
`timescale 1ns/1ps
`default_nettype none
module mcss_checker (
    input wire logic        hclk,
    input wire logic        hresetn,
    input wire logic        hsel,
    input wire logic [1:0]  htrans,
    input wire logic        hwrite,
    input wire logic        hready,
    input wire logic        hreadyout,
    input wire logic [31:0] hrdata,
    input wire logic        hresp,
    input wire logic        fast_osc_enable,
    input wire logic [2:0]  fast_osc_freq,
    input wire logic        crystal_osc_enable,
    input wire logic        crystal_port_data,
    input wire logic        cpu_clk_en,
    input wire logic        periph_clk_en
);
    default clocking @(posedge hclk); endclocking
    default disable iff (!hresetn);

    // Accepted address phases of each direction
    sequence rd_take;
        hsel && hready && htrans[1] && !hwrite;
    endsequence
    sequence wr_take;
        hsel && hready && htrans[1] && hwrite;
    endsequence
    // A read holds the bus for exactly one wait state
    sequence rd_wait;
        !hreadyout ##1 hreadyout;
    endsequence

    bus_okay_a: assert property (hresp == 1'h0)
        else $error("bus response not okay");
    read_wait_a: assert property (rd_take |=> rd_wait)
        else $error("read wait state wrong");
    write_nowait_a: assert property (wr_take |=> hreadyout)
        else $error("write data phase stalled");
    ready_single_a: assert property (!hreadyout |=> hreadyout)
        else $error("wait state longer than one cycle");
    rdata_upper_a: assert property ($rose(hreadyout) |-> hrdata[31:8] == 24'h000000)
        else $error("read data upper bits not zero");
    clk_common_a: assert property (cpu_clk_en |-> periph_clk_en)
        else $error("cpu tick without peripheral tick");
    reset_start_a: assert property ($rose(hresetn) |-> fast_osc_enable && !crystal_osc_enable)
        else $error("reset release not on internal oscillator");
    port_input_a: assert property (crystal_osc_enable |-> !crystal_port_data)
        else $error("crystal pins read as port while oscillating");
    // The tick after the divider update is the first of the suppressed ones
    freq_quiet_a: assert property ($changed(fast_osc_freq) && $past(hresetn, 2) |-> ##1 (!cpu_clk_en && !periph_clk_en) [*7])
        else $error("ticks not held after frequency change");
endmodule

bind mcss_main_clock_switch mcss_checker u_chk (
    .hclk(hclk), .hresetn(hresetn), .hsel(hsel), .htrans(htrans), .hwrite(hwrite),
    .hready(hready), .hreadyout(hreadyout), .hrdata(hrdata), .hresp(hresp),
    .fast_osc_enable(fast_osc_enable), .fast_osc_freq(fast_osc_freq),
    .crystal_osc_enable(crystal_osc_enable), .crystal_port_data(crystal_port_data),
    .cpu_clk_en(cpu_clk_en), .periph_clk_en(periph_clk_en)
);
`default_nettype wire

// ===== testbench/tb_top.sv
// Self-checking bench for the main clock source switch
`timescale 1ns/1ps
`default_nettype none
`include "mcss_cfg.svh"
module tb_top;
    logic        hclk;
    logic        hresetn;
    logic        hsel;
    logic [31:0] haddr;
    logic [1:0]  htrans;
    logic        hwrite;
    logic [31:0] hwdata;
    logic        hreadyout;
    logic [31:0] hrdata;
    logic        hresp;
    logic        fast_pin = 1'h0;
    logic        crystal_pin = 1'h1;
    logic        halt_req;
    logic        stop_req;
    logic        wake_req;
    logic        fast_osc_enable;
    logic [2:0]  fast_osc_freq;
    logic        crystal_osc_enable;
    logic        crystal_gain_high;
    logic        crystal_port_data;
    logic        cpu_clk_en;
    logic        periph_clk_en;
    logic [1:0]  div = 2'h0;
    int          cycles = 0;
    int          n_mismatch = 0;
    int          checks_done = 0;

    mcss_main_clock_switch uut (
        .hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr), .htrans(htrans),
        .hwrite(hwrite), .hsize(3'h2), .hwdata(hwdata), .hready(hreadyout),
        .hreadyout(hreadyout), .hrdata(hrdata), .hresp(hresp), .opt_freq_sel(3'h2),
        .fast_osc_in(fast_pin), .crystal_osc_in(crystal_pin), .ext_clk_in(div[1]),
        .halt_req(halt_req), .stop_req(stop_req), .wake_req(wake_req),
        .fast_osc_enable(fast_osc_enable), .fast_osc_freq(fast_osc_freq),
        .crystal_osc_enable(crystal_osc_enable), .crystal_gain_high(crystal_gain_high),
        .crystal_port_data(crystal_port_data), .cpu_clk_en(cpu_clk_en),
        .periph_clk_en(periph_clk_en)
    );

    initial begin
        hclk = 1'h0;
        forever #2.5 hclk = ~hclk;
    end

    // Oscillator pins run only while enabled: internal 8 hclk, crystal 4 hclk period
    always @(posedge hclk) begin
        div <= div + 2'h1;
        if (crystal_osc_enable && div[0])
            crystal_pin <= ~crystal_pin;
        if (fast_osc_enable && div == 2'h3)
            fast_pin <= ~fast_pin;
    end

    // Hang guard, well above the three crystal waits of about 4100 cycles each
    always @(posedge hclk) begin
        cycles <= cycles + 1;
        if (cycles == 30000) begin
            n_mismatch++;
            test_done();
        end
    end

    task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
        checks_done++;
        if (seen !== exp) begin
            n_mismatch++;
            $display("Error %s expected %h seen %h", nm, exp, seen);
        end
    endtask

    // One AHB-Lite single word transfer; each phase held until hready is seen high
    task automatic bus(input logic wr, input logic [7:0] a, input logic [7:0] d,
                       output logic [7:0] q);
        @(posedge hclk);
        hsel <= 1'h1;
        haddr <= {24'h000000, a};
        htrans <= 2'h2;
        hwrite <= wr;
        do @(posedge hclk); while (hreadyout !== 1'h1);
        htrans <= 2'h0;
        hwdata <= {24'h000000, d};
        do @(posedge hclk); while (hreadyout !== 1'h1);
        q = hrdata[7:0];
    endtask

    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        logic [7:0] q;
        bus(1'h1, a, d, q);
    endtask

    task automatic rd(input string nm, input logic [7:0] a, input logic [7:0] e);
        logic [7:0] q;
        bus(1'h0, a, 8'h00, q);
        chk(nm, q, e);
    endtask

    // Counts ticks over 40 cycles, sampled once the edge has settled
    task automatic tick_chk(input int ec, input int ep);
        int c;
        int p;
        c = 0;
        p = 0;
        repeat (40) begin
            @(posedge hclk);
            #1;
            if (cpu_clk_en === 1'h1) c++;
            if (periph_clk_en === 1'h1) p++;
        end
        chk("cpu ticks", c, ec);
        chk("periph ticks", p, ep);
    endtask

    task automatic pulse(input int which);
        @(posedge hclk);
        halt_req <= (which == 0);
        stop_req <= (which == 1);
        wake_req <= (which == 2);
        @(posedge hclk);
        {halt_req, stop_req, wake_req} <= 3'h0;
    endtask

    task automatic t_reset;
        rd("mode", `MCSS_OFF_MODE, `MCSS_RST_MODE);
        rd("run", `MCSS_OFF_RUN, `MCSS_RST_RUN);
        rd("stsel", `MCSS_OFF_STSEL, `MCSS_RST_STSEL);
        rd("sel", `MCSS_OFF_SEL, `MCSS_RST_SEL);
        rd("freq", `MCSS_OFF_FREQ, 8'h02);
        rd("stat", `MCSS_OFF_STAT, 8'h00);
        rd("unmapped", 8'h20, 8'h00);
        chk("port data", crystal_port_data, 1'h1);
        tick_chk(5, 5);
        $display("test reset done");
    endtask

    task automatic t_mode;
        wr(`MCSS_OFF_MODE, 8'h41);
        rd("mode", `MCSS_OFF_MODE, 8'h41);
        chk("gain", crystal_gain_high, 1'h1);
        chk("port data", crystal_port_data, 1'h0);
        wr(`MCSS_OFF_MODE, 8'h80);
        rd("mode again", `MCSS_OFF_MODE, 8'h41);
        wr(`MCSS_OFF_STAT, 8'hFF);
        rd("stat ro", `MCSS_OFF_STAT, 8'h00);
        $display("test mode done");
    endtask

    // Start-up order: wait select, run, poll counter, then select the crystal
    task automatic t_crystal;
        logic [7:0] q;
        logic [7:0] inv;
        logic [7:0] f;
        int         i;
        wr(`MCSS_OFF_STSEL, 8'h02);
        rd("stsel", `MCSS_OFF_STSEL, 8'h02);
        wr(`MCSS_OFF_RUN, 8'h00);
        #1 chk("crystal on", crystal_osc_enable, 1'h1);
        for (i = 0; i < 2000; i++) begin
            bus(1'h0, `MCSS_OFF_STAT, 8'h00, q);
            inv = ~q;
            f = inv & (inv + 8'h01);
            chk("stat form", f, 8'h00);
            if (q[5] === 1'h1) break;
        end
        chk("stat", q, 8'hE0);
        wr(`MCSS_OFF_SEL, 8'h10);
        q = 8'h00;
        for (i = 0; i < 10 && q[5] !== 1'h1; i++) bus(1'h0, `MCSS_OFF_SEL, 8'h00, q);
        chk("sel crystal", q, 8'h30);
        tick_chk(10, 10);
        $display("test crystal done");
    endtask

    task automatic t_back;
        logic [7:0] q;
        int         i;
        q = 8'h30;
        wr(`MCSS_OFF_SEL, 8'h00);
        for (i = 0; i < 10 && q[5] !== 1'h0; i++) bus(1'h0, `MCSS_OFF_SEL, 8'h00, q);
        chk("sel internal", q, 8'h00);
        tick_chk(5, 5);
        wr(`MCSS_OFF_RUN, 8'h80);
        #1 chk("crystal off", crystal_osc_enable, 1'h0);
        $display("test back done");
    endtask

    // STOP on the crystal: no ticks until the selected stabilization count is reached
    task automatic t_stop;
        pulse(1);
        tick_chk(0, 0);
        pulse(2);
        repeat (4000) @(posedge hclk);
        tick_chk(0, 0);
        repeat (100) @(posedge hclk);
        tick_chk(10, 10);
        $display("test stop done");
    endtask

    // External clock needs both select bits and the stop bit clear, but no wait
    task automatic t_ext;
        logic [7:0] q;
        int         i;
        q = 8'h00;
        wr(`MCSS_OFF_MODE, 8'hC0);
        wr(`MCSS_OFF_RUN, 8'h00);
        #1 chk("ext no crystal", crystal_osc_enable, 1'h0);
        wr(`MCSS_OFF_SEL, 8'h10);
        for (i = 0; i < 10 && q[5] !== 1'h1; i++) bus(1'h0, `MCSS_OFF_SEL, 8'h00, q);
        chk("sel external", q, 8'h30);
        tick_chk(10, 10);
        $display("test ext done");
    endtask

    task automatic t_power;
        wr(`MCSS_OFF_FREQ, 8'h03);
        repeat (60) @(posedge hclk);
        chk("freq out", fast_osc_freq, 3'h3);
        rd("freq", `MCSS_OFF_FREQ, 8'h03);
        pulse(0);
        tick_chk(0, 5);
        pulse(2);
        tick_chk(5, 5);
        pulse(1);
        #1 chk("stop enable", fast_osc_enable, 1'h0);
        tick_chk(0, 0);
        pulse(2);
        repeat (16) @(posedge hclk);
        tick_chk(5, 5);
        $display("test power done");
    endtask

    task automatic test_done;
        $display("checks %0d mismatches %0d", checks_done, n_mismatch);
        if (n_mismatch == 0 && checks_done > 0)
            $display("verification passed");
        else
            $display("verification failed");
        $finish;
    endtask

    initial begin
        {hresetn, hsel, hwrite, halt_req, stop_req, wake_req} = 6'h00;
        {haddr, hwdata, htrans} = 66'h0;
        repeat (3) @(posedge hclk);
        hresetn <= 1'h1;
        t_reset();
        t_mode();
        t_crystal();
        // Reset while running on the crystal must come back on the internal source
        @(posedge hclk);
        hresetn <= 1'h0;
        repeat (3) @(posedge hclk);
        hresetn <= 1'h1;
        rd("sel after reset", `MCSS_OFF_SEL, 8'h00);
        tick_chk(5, 5);
        wr(`MCSS_OFF_MODE, 8'h41);
        rd("mode rewrite", `MCSS_OFF_MODE, 8'h41);
        t_crystal();
        t_stop();
        t_back();
        t_power();
        // A fresh reset frees the one-shot mode register for external input
        @(posedge hclk);
        hresetn <= 1'h0;
        repeat (3) @(posedge hclk);
        hresetn <= 1'h1;
        t_ext();
        test_done();
    end
endmodule
`default_nettype wire
